/* File: rtl/nand_card_bus_control.sv */
`timescale 1ns/1ps
// ****************************************
// read data buffer
// ****************************************
module byte_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [AW:0]   cnt_reg, cnt_next;
	logic          push, pop;

	// pointer and fill level next values
	always_comb begin
		push     = in_valid && in_ready;
		pop      = out_valid && out_ready;
		wp_next  = push ? AW'((wp_reg + 1'b1) % D) : wp_reg;
		rp_next  = pop ? AW'((rp_reg + 1'b1) % D) : rp_reg;
		cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			wp_reg  <= wp_next;
			rp_reg  <= rp_next;
			cnt_reg <= cnt_next;
		end
	end

	// storage carries no reset, only data
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_reg] <= in_data;
		end
	end

	assign in_ready  = (cnt_reg != (AW+1)'(D));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem[rp_reg];
endmodule : byte_fifo

`timescale 1ns/1ps
// ****************************************
// host sequencer for the card pins
// ****************************************
module nand_card_bus_control
	import nand_host_pkg::*;
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               resetn,
	// operation request
	input  wire logic               req_valid,
	input  wire req_t               req,
	output logic                    req_ready,
	input  wire logic               write_allow,
	output logic                    done,
	output logic                    refused,
	output logic                    fail,
	// invalid block marking
	input  wire logic               mark_bad,
	input  wire logic [10:0]        bad_block,
	// program data
	input  wire logic               wr_valid,
	input  wire logic [7:0]         wr_data,
	output logic                    wr_ready,
	// read data
	output logic                    rd_valid,
	input  wire logic               rd_ready,
	output logic [7:0]              rd_data,
	// card pins
	output pins_t                   pins,
	input  wire logic [7:0]         io_in,
	input  wire logic               rb_n
);
	// ****************************************
	// reset release and input synchronisers
	// ****************************************
	logic       rst_a, rst_n;
	logic [7:0] io_a, io_s;
	logic       rb_a, rb_s;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_a <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_a <= 1'b1;
			rst_n <= rst_a;
		end
	end

	// open-drain busy line is only ever sampled here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			io_a <= 8'h00;
			io_s <= 8'h00;
			rb_a <= 1'b1;
			rb_s <= 1'b1;
		end else begin
			io_a <= io_in;
			io_s <= io_a;
			rb_a <= rb_n;
			rb_s <= rb_a;
		end
	end

	// ****************************************
	// sequencer state
	// ****************************************
	state_t            state_reg, state_next;
	phase_t            ph_reg, ph_next;
	logic [3:0]        cnt_reg, cnt_next;
	logic [2:0]        seq_reg, seq_next;
	logic [1:0]        idx_reg, idx_next;
	logic [9:0]        num_reg, num_next;
	logic [7:0]        byte_reg, byte_next;
	req_t              r_reg, r_next;
	pins_t             pins_reg, pins_next;
	logic              done_reg, done_next, ref_reg, ref_next;
	logic              fail_reg, fail_next;
	logic              rdy_reg, rdy_next, wrr_reg, wrr_next;
	logic [BLOCKS-1:0] bad_reg, bad_next;
	logic [15:0]       last_reg, last_next;
	logic              trk_reg, trk_next;
	logic [1:0]        mcnt_reg, mcnt_next, scnt_reg, scnt_next;
	logic              push, fifo_ready, strobe_end, same_pg, over;
	logic [7:0]        ptr_cmd;

	// pointer command for the area of the incoming request
	always_comb begin
		case (req.area)
			AREA_B:     ptr_cmd = CMD_PTR_B;
			AREA_SPARE: ptr_cmd = CMD_PTR_C;
			default:    ptr_cmd = CMD_PTR_A;
		endcase
	end

	// next values of the whole sequencer
	always_comb begin
		state_next = state_reg;
		ph_next    = ph_reg;
		cnt_next   = cnt_reg + 4'h1;
		seq_next   = seq_reg;
		idx_next   = idx_reg;
		num_next   = num_reg;
		byte_next  = byte_reg;
		r_next     = r_reg;
		done_next  = 1'b0;
		ref_next   = 1'b0;
		fail_next  = fail_reg;
		bad_next   = bad_reg;
		last_next  = last_reg;
		trk_next   = trk_reg;
		mcnt_next  = mcnt_reg;
		scnt_next  = scnt_reg;
		push       = 1'b0;
		// blocks found invalid, at delivery or later
		if (mark_bad) begin
			bad_next[bad_block] = 1'b1;
		end
		same_pg = trk_reg && (req.row == last_reg);
		over    = same_pg && ((req.area == AREA_SPARE) ?
		          (scnt_reg >= SPARE_LIMIT) : (mcnt_reg >= MAIN_LIMIT));
		strobe_end = (ph_reg == PH_HIGH) && (cnt_reg == WH_CYC - 4'h1);
		case (state_reg)
			S_IDLE: begin
				if (req_valid && rdy_reg) begin
					if (req.op != OP_READ && (!write_allow || over
					    || bad_reg[req.row[15:BLOCK_LSB]])) begin
						done_next = 1'b1;
						ref_next  = 1'b1;
					end else begin
						r_next     = req;
						seq_next   = 3'h0;
						idx_next   = (req.op == OP_ERASE) ? 2'h1 : 2'h0;
						num_next   = 10'h000;
						fail_next  = 1'b0;
						state_next = S_CMD;
						ph_next    = PH_LOW;
						cnt_next   = 4'h0;
						// reads and programs open with the area pointer
						byte_next  = (req.op == OP_ERASE) ? CMD_ERASE : ptr_cmd;
					end
				end
			end
			S_CMD, S_ADDR, S_WDATA: begin
				// strobe low, then high with bus and latch selects held
				if (ph_reg == PH_FETCH) begin
					cnt_next = 4'h0;
					if (wr_valid && wrr_reg) begin
						byte_next = wr_data;
						ph_next   = PH_LOW;
					end
				end else if (ph_reg == PH_LOW) begin
					if (cnt_reg == WP_CYC - 4'h1) begin
						ph_next  = PH_HIGH;
						cnt_next = 4'h0;
					end
				end else if (strobe_end) begin
					ph_next  = PH_LOW;
					cnt_next = 4'h0;
					if (state_reg == S_CMD) begin
						seq_next = seq_reg + 3'h1;
						if (r_reg.op == OP_PROG && seq_reg == 3'h0) begin
							byte_next = CMD_PROG;
						end else if (r_reg.op == OP_PROG && seq_reg == 3'h2
						          || r_reg.op == OP_ERASE && seq_reg == 3'h1) begin
							state_next = S_WAITB;
						end else if (r_reg.op == OP_PROG && seq_reg == 3'h3
						          || r_reg.op == OP_ERASE && seq_reg == 3'h2) begin
							state_next = S_STAT;
							ph_next    = PH_FETCH;
						end else begin
							state_next = S_ADDR;
							byte_next  = (r_reg.op == OP_ERASE) ?
							             r_reg.row[7:0] : r_reg.col;
						end
					end else if (state_reg == S_ADDR) begin
						// column, row low, row high in that order; an erase starts at row low
						idx_next = idx_reg + 2'h1;
						if (idx_reg == 2'h0) begin
							byte_next = r_reg.row[7:0];
						end else if (idx_reg == 2'h1) begin
							byte_next = r_reg.row[15:8];
						end else if (r_reg.op == OP_READ) begin
							state_next = S_WAITB;
						end else if (r_reg.op == OP_PROG) begin
							state_next = S_WDATA;
							ph_next    = PH_FETCH;
						end else begin
							state_next = S_CMD;
							byte_next  = CMD_ERASE_GO;
						end
					end else begin
						num_next = num_reg + 10'h001;
						if (num_reg == r_reg.len - 10'h001) begin
							state_next = S_CMD;
							byte_next  = CMD_PROG_GO;
						end else begin
							ph_next = PH_FETCH;
						end
					end
				end
			end
			S_WAITB: begin
				// busy is not valid until the strobe-to-busy delay
				if (cnt_reg == WB_CYC - 4'h1) begin
					state_next = S_WAITRB;
				end
			end
			S_WAITRB: begin
				cnt_next = 4'h0;
				if (rb_s) begin
					if (r_reg.op == OP_READ) begin
						state_next = S_RDATA;
						ph_next    = PH_FETCH;
					end else begin
						state_next = S_CMD;
						ph_next    = PH_LOW;
						byte_next  = CMD_STATUS;
					end
				end
			end
			S_RDATA, S_STAT: begin
				if (ph_reg == PH_FETCH) begin
					// data read waits for buffer room, status for tWHR
					if (state_reg == S_RDATA) begin
						cnt_next = 4'h0;
						if (fifo_ready) begin
							ph_next = PH_LOW;
						end
					end else if (cnt_reg == WHR_CYC - 4'h1) begin
						ph_next  = PH_LOW;
						cnt_next = 4'h0;
					end
				end else if (ph_reg == PH_LOW) begin
					if (cnt_reg == REA_CYC - 4'h1) begin
						ph_next  = PH_HIGH;
						cnt_next = 4'h0;
						if (state_reg == S_RDATA) begin
							push = 1'b1;
						end else begin
							fail_next = io_s[STATUS_FAIL_BIT];
						end
					end
				end else if (cnt_reg == REH_CYC - 4'h1) begin
					// every data strobe moves on to the next column; the status strobe ends the operation
					num_next = num_reg + 10'h001;
					cnt_next = 4'h0;
					if (state_reg == S_STAT || num_reg == r_reg.len - 10'h001) begin
						state_next = S_FINISH;
					end else begin
						ph_next = PH_FETCH;
					end
				end
			end
			S_FINISH: begin
				// select high long enough to really end the read
				if (cnt_reg == CEH_CYC - 4'h1) begin
					state_next = S_IDLE;
					done_next  = 1'b1;
					// only the last programmed page is tracked
					if (r_reg.op == OP_PROG) begin
						if (!trk_reg || last_reg != r_reg.row) begin
							mcnt_next = 2'h0;
							scnt_next = 2'h0;
						end
						if (trk_reg && last_reg == r_reg.row
						    || !trk_reg || last_reg != r_reg.row) begin
							last_next = r_reg.row;
							trk_next  = 1'b1;
						end
						if (r_reg.area == AREA_SPARE) begin
							scnt_next = ((trk_reg && last_reg == r_reg.row) ?
							             scnt_reg : 2'h0) + 2'h1;
						end else begin
							mcnt_next = ((trk_reg && last_reg == r_reg.row) ?
							             mcnt_reg : 2'h0) + 2'h1;
						end
					end else if (r_reg.op == OP_ERASE && last_reg[15:BLOCK_LSB]
					             == r_reg.row[15:BLOCK_LSB]) begin
						trk_next = 1'b0;
					end
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
		// pins other than wp_n follow the next state so they leave a flip-flop
		pins_next.ce_n = (state_next == S_IDLE) || (state_next == S_FINISH);
		pins_next.cle  = (state_next == S_CMD);
		pins_next.ale  = (state_next == S_ADDR);
		pins_next.we_n = !((state_next inside {S_CMD, S_ADDR, S_WDATA})
		                 && ph_next == PH_LOW);
		pins_next.output_strobe_n = !((state_next inside {S_RDATA, S_STAT})
		                 && ph_next == PH_LOW);
		pins_next.io_oe = (state_next inside {S_CMD, S_ADDR, S_WDATA})
		                 && ph_next != PH_FETCH;
		pins_next.io_out = byte_next;
		pins_next.wp_n   = write_allow;
		rdy_next = (state_next == S_IDLE);
		wrr_next = (state_next == S_WDATA) && (ph_next == PH_FETCH);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
			ph_reg    <= PH_LOW;
			cnt_reg   <= 4'h0;
			seq_reg   <= 3'h0;
			idx_reg   <= 2'h0;
			num_reg   <= 10'h000;
			byte_reg  <= 8'h00;
			r_reg     <= '0;
			pins_reg  <= '{ce_n: 1'b1, we_n: 1'b1, output_strobe_n: 1'b1,
			               default: '0}; // write-locked during reset
			done_reg  <= 1'b0;
			ref_reg   <= 1'b0;
			fail_reg  <= 1'b0;
			rdy_reg   <= 1'b0;
			wrr_reg   <= 1'b0;
			bad_reg   <= '0;
			last_reg  <= 16'h0000;
			trk_reg   <= 1'b0;
			mcnt_reg  <= 2'h0;
			scnt_reg  <= 2'h0;
		end else begin
			state_reg <= state_next;
			ph_reg    <= ph_next;
			cnt_reg   <= cnt_next;
			seq_reg   <= seq_next;
			idx_reg   <= idx_next;
			num_reg   <= num_next;
			byte_reg  <= byte_next;
			r_reg     <= r_next;
			pins_reg  <= pins_next;
			done_reg  <= done_next;
			ref_reg   <= ref_next;
			fail_reg  <= fail_next;
			rdy_reg   <= rdy_next;
			wrr_reg   <= wrr_next;
			bad_reg   <= bad_next;
			last_reg  <= last_next;
			trk_reg   <= trk_next;
			mcnt_reg  <= mcnt_next;
			scnt_reg  <= scnt_next;
		end
	end

	// back-pressure from the reader stalls the read strobe
	byte_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) rd_buf (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.in_data   (io_s),
		.out_valid (rd_valid),
		.out_ready (rd_ready),
		.out_data  (rd_data)
	);

	assign pins      = pins_reg;
	assign req_ready = rdy_reg;
	assign wr_ready  = wrr_reg;
	assign done      = done_reg;
	assign refused   = ref_reg;
	assign fail      = fail_reg;
endmodule : nand_card_bus_control

/* File: rtl/nand_host_pkg.sv */
package nand_host_pkg;
	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_MHZ     = 40;
	localparam int SYNC_STAGES = 2;
	localparam int T_WP_NS     = 25;  // write strobe low
	localparam int T_WH_NS     = 15;  // write strobe high
	localparam int T_REA_NS    = 35;  // read access
	localparam int T_REH_NS    = 15;  // read strobe high
	localparam int T_WB_NS     = 100; // strobe rise to busy
	localparam int T_WHR_NS    = 60;  // write high to read low
	localparam int T_CEH_NS    = 100; // select high hold
	localparam logic [3:0] WP_CYC  = 4'((T_WP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] WH_CYC  = 4'((T_WH_NS * CLK_MHZ + 999) / 1000);
	// one extra cycle of margin behind the input synchroniser
	localparam logic [3:0] REA_CYC = 4'((T_REA_NS * CLK_MHZ + 999) / 1000
	                                    + SYNC_STAGES + 1);
	localparam logic [3:0] REH_CYC = 4'((T_REH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] WB_CYC  = 4'((T_WB_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] WHR_CYC = 4'((T_WHR_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] CEH_CYC = 4'((T_CEH_NS * CLK_MHZ + 999) / 1000);

	// ****************************************
	// organisation and commands
	// ****************************************
	localparam int BLOCKS      = 2048;
	localparam int BLOCK_LSB   = 5;   // 32 pages per block
	localparam int FIFO_DEPTH  = 8;
	localparam int DATA_W      = 8;
	localparam logic [1:0] MAIN_LIMIT  = 2'h1;
	localparam logic [1:0] SPARE_LIMIT = 2'h2;
	localparam logic [7:0] CMD_PTR_A   = 8'h00;
	localparam logic [7:0] CMD_PTR_B   = 8'h01;
	localparam logic [7:0] CMD_PTR_C   = 8'h50;
	localparam logic [7:0] CMD_PROG    = 8'h80;
	localparam logic [7:0] CMD_PROG_GO = 8'h10;
	localparam logic [7:0] CMD_ERASE   = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
	localparam logic [7:0] CMD_STATUS  = 8'h70;
	localparam int STATUS_FAIL_BIT     = 0;

	typedef enum logic [1:0] {
		OP_READ  = 2'h0,
		OP_PROG  = 2'h1,
		OP_ERASE = 2'h2
	} op_t;

	typedef enum logic [1:0] {
		AREA_A     = 2'h0,
		AREA_B     = 2'h1,
		AREA_SPARE = 2'h2
	} area_t;

	typedef enum logic [1:0] {
		PH_LOW   = 2'h0,
		PH_HIGH  = 2'h1,
		PH_FETCH = 2'h2
	} phase_t;

	typedef enum logic [3:0] {
		S_IDLE   = 4'h0,
		S_CMD    = 4'h1,
		S_ADDR   = 4'h2,
		S_WDATA  = 4'h3,
		S_WAITB  = 4'h4,
		S_WAITRB = 4'h5,
		S_RDATA  = 4'h6,
		S_STAT   = 4'h7,
		S_FINISH = 4'h8
	} state_t;

	typedef struct packed {
		op_t         op;
		area_t       area;
		logic [7:0]  col;
		logic [15:0] row;
		logic [9:0]  len;
	} req_t;

	typedef struct packed {
		logic       ce_n;
		logic       cle;
		logic       ale;
		logic       we_n;
		logic       output_strobe_n;
		logic       wp_n;
		logic       io_oe;
		logic [7:0] io_out;
	} pins_t;
endpackage : nand_host_pkg

/* File: sim/nand_bus_checker_assertions.sv */
`timescale 1ns/1ps
// ****************************************
// pin protocol checker
// ****************************************
module nand_bus_checker
	import nand_host_pkg::*;
(
	// clock and reset
	input wire logic  clk,
	input wire logic  resetn,
	// request side
	input wire logic  req_valid,
	input wire req_t  req,
	input wire logic  req_ready,
	input wire logic  write_allow,
	input wire logic  done,
	input wire logic  refused,
	// card side
	input wire pins_t pins,
	input wire logic  rb_n
);
	logic [2:0] up_reg;
	logic [2:0] up_next;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// settle count, the internal reset lags the port by the synchroniser
	always_comb up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
	always_ff @(posedge clk or negedge resetn)
		if (!resetn) up_reg <= 3'h0;
		else up_reg <= up_next;
	property p_rd_qual; !pins.output_strobe_n |-> !pins.ce_n && !pins.cle
		&& !pins.ale && pins.we_n && !pins.io_oe; endproperty
	a_rd_qual: assert property (p_rd_qual) else $error("read mode bad");
	property p_rd_len; $fell(pins.output_strobe_n) |->
		!pins.output_strobe_n [*5] ##1 pins.output_strobe_n; endproperty
	a_rd_len: assert property (p_rd_len) else $error("read pulse len");
	property p_rd_rdy;
		$fell(pins.output_strobe_n) |-> $past(rb_n, 2) && rb_n; endproperty
	a_rd_rdy: assert property (p_rd_rdy) else $error("read while busy");
	property p_we_qual; !pins.we_n |-> !pins.ce_n && pins.io_oe
		&& !(pins.cle && pins.ale); endproperty
	a_we_qual: assert property (p_we_qual) else $error("write mode bad");
	property p_we_len; $fell(pins.we_n) |=> pins.we_n && $stable(pins.io_out)
		&& $stable(pins.cle) && $stable(pins.ale); endproperty
	a_we_len: assert property (p_we_len) else $error("write pulse bad");
	property p_addr; $fell(pins.we_n) && pins.cle && pins.io_out == CMD_PROG
		|-> ##2 (pins.ale && !pins.we_n) ##2 (pins.ale && !pins.we_n)
		##2 (pins.ale && !pins.we_n); endproperty
	a_addr: assert property (p_addr) else $error("address count");
	property p_wp;
		up_reg == 3'h7 |-> pins.wp_n == $past(write_allow); endproperty
	a_wp: assert property (p_wp) else $error("lock pin lag");
	property p_refuse; req_valid && req_ready && req.op != OP_READ
		&& !write_allow |=> done && refused; endproperty
	a_refuse: assert property (p_refuse) else $error("locked op run");
	property p_done;
		done |-> pins.ce_n && pins.we_n && pins.output_strobe_n; endproperty
	a_done: assert property (p_done) else $error("done while selected");
	c_refuse: cover property (done && refused);
	c_read: cover property ($fell(pins.output_strobe_n));
	c_prog: cover property ($fell(pins.we_n) && pins.io_out == CMD_PROG);
endmodule : nand_bus_checker

bind nand_card_bus_control nand_bus_checker chk (.clk, .resetn, .req_valid,
	.req, .req_ready, .write_allow, .done, .refused, .pins, .rb_n);

/* File: sim/nand_card_model.sv */
`timescale 1ns/1ps
// ****************************************
// behavioural card on the far side
// ****************************************
module nand_card_model
	import nand_host_pkg::*;
#(
	parameter int BUSY_CYC = 20
) (
	// busy timing and host pins
	input  wire logic  clk,
	input  wire pins_t pins,
	// card outputs
	output logic [7:0] card_io,
	output logic       rb_oe
);
	logic [7:0] mem [256];
	logic [7:0] cmd, col, dout, ptr;
	logic       stat, fetch;
	int         acnt, busy;
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		{cmd, col, dout, ptr, stat, fetch, acnt, busy} = '0;
	end
	// pulls low while busy, even when deselected
	assign rb_oe = (busy != 0);
	always @(posedge clk) if (busy != 0) busy <= busy - 1;
	// released lines show the last byte inverted, not a stale copy
	assign card_io = (!pins.ce_n && !pins.output_strobe_n) ? dout : ~dout;
	// latch on write strobe rise
	always @(posedge pins.we_n) if (pins.ce_n === 1'b0) begin
		if (pins.cle) begin
			cmd = pins.io_out;
			acnt = 0;
			stat = (cmd == CMD_STATUS);
			// remember the last area pointer the host chose
			if (cmd inside {CMD_PTR_A, CMD_PTR_B, CMD_PTR_C}) ptr = cmd;
			// generator held in reset while locked
			if (pins.wp_n && (cmd == CMD_PROG_GO || cmd == CMD_ERASE_GO)) begin
				busy = BUSY_CYC;
				fetch = 1'b0;
			end
			if (pins.wp_n && cmd == CMD_ERASE_GO) foreach (mem[i]) mem[i] = 8'hff;
		end else if (pins.ale) begin
			if (acnt == 0 && cmd != CMD_ERASE) col = pins.io_out;
			acnt++;
			// third byte of a read starts the page fetch
			if (acnt == 3 && cmd != CMD_PROG) begin
				busy = BUSY_CYC;
				fetch = 1'b1;
			end
		end else begin
			if (pins.wp_n) mem[col] = pins.io_out;
			col++;
		end
	end
	// each strobe fall puts out the next byte
	always @(negedge pins.output_strobe_n) if (pins.ce_n === 1'b0) begin
		dout = stat ? {pins.wp_n, !rb_oe, 6'h00} : mem[col];
		if (!stat) col++;
	end
	// deselect ends a fetch, never a program or erase
	always @(posedge pins.ce_n) if (fetch) busy = 0;
endmodule : nand_card_model

/* File: sim/tb_nand_card_bus_control.sv */
`timescale 1ns/1ps
module tb_nand_card_bus_control import nand_host_pkg::*;;
	localparam logic [7:0] PAT [4] = '{8'ha5, 8'h5a, 8'hc3, 8'h3c};
	logic        clk, resetn, req_valid, req_ready, write_allow, done;
	logic        refused, fail, mark_bad, wr_valid, wr_ready, rd_valid;
	logic        rd_ready, rb_oe, rb_n, drain, rf;
	logic [10:0] bad_block;
	logic [7:0]  wr_data, rd_data, io_in, card_io;
	req_t        req;
	pins_t       pins;
	logic [7:0]  wq[$], rq[$];
	int          fail_count, comparisons, strobes;
	// ****************************************
	// design, card and wires
	// ****************************************
	nand_card_bus_control dut (.clk, .resetn, .req_valid, .req, .req_ready,
		.write_allow, .done, .refused, .fail, .mark_bad, .bad_block, .wr_valid,
		.wr_data, .wr_ready, .rd_valid, .rd_ready, .rd_data, .pins, .io_in,
		.rb_n);
	nand_card_model card (.clk, .pins, .card_io, .rb_oe);
	assign rb_n  = rb_oe ? 1'b0 : 1'b1; // pull-up on the busy line
	assign io_in = pins.io_oe ? pins.io_out : card_io;
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// feed program bytes, collect read bytes, count read strobes
	always @(posedge clk) begin
		if (wr_valid === 1'b1 && wr_ready === 1'b1) void'(wq.pop_front());
		if (rd_valid === 1'b1 && rd_ready === 1'b1) rq.push_back(rd_data);
		#1 wr_valid = (wq.size() != 0);
		wr_data = (wq.size() != 0) ? wq[0] : 8'h00;
		rd_ready = drain;
	end
	always @(negedge pins.output_strobe_n) strobes++;
	task automatic check(input string what, input logic [7:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// one request, held until taken, then wait for its completion
	task automatic run(input op_t o, input area_t a, input logic [7:0] c,
		input logic [15:0] r, input logic [9:0] n);
		req = '{op: o, area: a, col: c, row: r, len: n};
		req_valid = 1'b1;
		@(posedge clk);
		while (req_ready !== 1'b1) @(posedge clk);
		#1 req_valid = 1'b0;
		for (int k = 0; k < 2000 && done !== 1'b1; k++) @(posedge clk) #1;
		check("op finished", done, 1'b1);
		rf = refused;
	endtask : run
	task automatic t_prog;
		run(OP_ERASE, AREA_A, 8'h00, 16'h0020, 10'h000);
		check("erase refused", rf, 1'b0);
		foreach (PAT[i]) wq.push_back(PAT[i]);
		run(OP_PROG, AREA_A, 8'h10, 16'h0020, 10'h004);
		check("program refused", rf, 1'b0);
		check("program fail", fail, 1'b0);
		check("bytes left", 8'(wq.size()), 8'h00);
		run(OP_PROG, AREA_A, 8'h10, 16'h0020, 10'h004);
		check("second main program", rf, 1'b1);
		for (int i = 0; i < 3; i++) begin
			wq = '{8'hff};
			run(OP_PROG, AREA_SPARE, 8'h00, 16'h0020, 10'h001);
			check("spare program", rf, 8'(i == 2));
			wq.delete();
		end
		check("spare pointer", card.ptr, CMD_PTR_C);
		$display("program test finished");
	endtask : t_prog
	// host must stop strobing when the buffer is full
	task automatic t_read;
		int s0;
		s0 = strobes;
		drain = 1'b0;
		rq.delete();
		fork
			run(OP_READ, AREA_A, 8'h0c, 16'h0020, 10'h00c);
			begin
				repeat (400) @(posedge clk);
				check("strobes while stalled", 8'(strobes - s0), 8'h08);
				#1 drain = 1'b1;
			end
		join
		check("bytes read", 8'(rq.size()), 8'h0c);
		for (int i = 0; i < 12; i++)
			check("read byte", rq[i], (i > 3 && i < 8) ? PAT[i-4] : 8'hff);
		$display("read test finished");
	endtask : t_read
	task automatic t_lock;
		write_allow = 1'b0;
		rq.delete();
		repeat (3) @(posedge clk) #1;
		check("lock pin", pins.wp_n, 1'b0);
		run(OP_ERASE, AREA_A, 8'h00, 16'h0020, 10'h000);
		check("locked erase", rf, 1'b1);
		run(OP_READ, AREA_B, 8'h11, 16'h0020, 10'h001);
		check("locked read", rf, 1'b0);
		check("area pointer", card.ptr, CMD_PTR_B);
		check("locked read data", rq[0], PAT[1]);
		write_allow = 1'b1;
		$display("lock test finished");
	endtask : t_lock
	task automatic t_bad;
		bad_block = 11'h002;
		mark_bad = 1'b1;
		@(posedge clk) #1 mark_bad = 1'b0;
		run(OP_ERASE, AREA_A, 8'h00, 16'h0040, 10'h000);
		check("bad erase", rf, 1'b1);
		run(OP_PROG, AREA_A, 8'h00, 16'h0041, 10'h001);
		check("bad program", rf, 1'b1);
		run(OP_ERASE, AREA_A, 8'h00, 16'h0060, 10'h000);
		check("good erase", rf, 1'b0);
		$display("invalid block test finished");
	endtask : t_bad
	initial begin
		{resetn, req_valid, mark_bad} = '0;
		{write_allow, drain} = 2'h3;
		{bad_block, req, comparisons} = '0;
		repeat (6) @(posedge clk);
		check("reset lock pin", pins.wp_n, 1'b0);
		check("reset select", pins.ce_n, 1'b1);
		#1 resetn = 1'b1;
		t_prog();
		t_read();
		t_lock();
		t_bad();
		stop_test();
	end
	initial begin
		repeat (10000) @(posedge clk);
		fail_count++;
		stop_test();
	end
endmodule : tb_nand_card_bus_control
